/* File: rtl/rbt_pkg.sv */
package rbt_pkg;

    // Port geometry
    localparam int BUS_WIDTH   = 18;
    localparam int PIPE_STAGES = 3;
    localparam int SNOOP_DEPTH = 16;
    localparam int LEVEL_WIDTH = 5;
    localparam int CNT_WIDTH   = 16;

    // Register offsets, byte addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_SNOOP    = 8'h08;
    localparam logic [7:0] ADDR_AB_HOLD  = 8'h0c;
    localparam logic [7:0] ADDR_BA_HOLD  = 8'h10;
    localparam logic [7:0] ADDR_AB_COUNT = 8'h14;
    localparam logic [7:0] ADDR_BA_COUNT = 8'h18;

    // Control field positions and reset values
    localparam int CTRL_SNOOP_EN_BIT  = 0;
    localparam int CTRL_SNOOP_SRC_BIT = 1;
    localparam logic CTRL_SNOOP_EN_RST  = 1'b0;
    localparam logic CTRL_SNOOP_SRC_RST = 1'b0;

    // Status field positions
    localparam int STAT_LEVEL_LSB   = 0;
    localparam int STAT_EMPTY_BIT   = 8;
    localparam int STAT_FULL_BIT    = 9;
    localparam int STAT_OVF_BIT     = 10;
    localparam int STAT_SEL_BIT     = 11;
    localparam int STAT_A_DRIVE_BIT = 12;
    localparam int STAT_B_DRIVE_BIT = 13;
    localparam int SNOOP_VALID_BIT  = 31;

    // Reset values of the data path
    localparam logic [BUS_WIDTH-1:0] HOLD_RST  = 18'h00000;
    localparam logic [CNT_WIDTH-1:0] COUNT_RST = 16'h0000;

endpackage

/* File: rtl/rbt_fifo.sv */
`timescale 1ns/1ps
module rbt_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    // Filling side
    input  wire logic                       in_valid,
    output wire logic                       in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    // Draining side
    output wire logic                       out_valid,
    input  wire logic                       out_ready,
    output wire logic [WIDTH-1:0]           out_data,
    // Fill level
    output wire logic [$clog2(DEPTH):0]     level
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    // Honest flags straight from the count
    assign in_ready  = (count != DEPTH[PW:0]);
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign level     = count;

    // Storage has no reset, only pointers and count do
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers wrap naturally at a power-of-two depth
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule

/* File: rtl/rbt_core.sv */
// Overview of operation
// - Ports A and B are 18 bits wide each and bit n of one port moves only to bit n of the other.
// - A-to-B data passes through exactly one holding register before it appears on B.
// - A register loads only on a rising edge of its clock and only while its direction's clock enable is low.
// - The A-to-B register is loaded only by the A-to-B clock, never by either B-to-A clock.
// - B-to-A stages are loaded only by the stage-one and stage-two B-to-A clocks.
// - With the A-to-B clock enable high B holds, with it low a rising A-to-B clock copies A onto B.
// - With the B-to-A clock enable high, A keeps its level whatever clocks, path select or B do.
// - With path select high and clock enable low, a stage-two rising edge copies B straight onto A.
// - With path select low, B-to-A data runs through a four-stage pipeline.
// - In pipeline mode a B value needs three stage-one edges and one stage-two edge to reach A.
// - Each direction has its own active-low output enable and clock enable, driven independently.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module rbt_core
    import rbt_pkg::*;
(
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    // Port A pins
    input  wire logic [rbt_pkg::BUS_WIDTH-1:0] a_in,
    output wire logic [rbt_pkg::BUS_WIDTH-1:0] a_out,
    output wire logic                          a_oe_n,
    // Port B pins
    input  wire logic [rbt_pkg::BUS_WIDTH-1:0] b_in,
    output wire logic [rbt_pkg::BUS_WIDTH-1:0] b_out,
    output wire logic                          b_oe_n,
    // A-to-B direction controls
    input  wire logic                          a_to_b_clock,
    input  wire logic                          a_to_b_clock_enable_n,
    input  wire logic                          a_to_b_output_enable_n,
    // B-to-A direction controls
    input  wire logic                          b_to_a_stage_one_clock,
    input  wire logic                          b_to_a_stage_two_clock,
    input  wire logic                          b_to_a_clock_enable_n,
    input  wire logic                          b_to_a_output_enable_n,
    input  wire logic                          path_select,
    // Register port
    input  wire logic [7:0]                    reg_addr,
    input  wire logic [31:0]                   reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output wire logic [31:0]                   reg_rdata,
    // Snoop buffer back-pressure
    output wire logic                          snoop_ready
);

    import rbt_pkg::*;

    // Edge history of the three device clocks
    logic ab_clk_q;
    logic s1_clk_q;
    logic s2_clk_q;

    // Holding registers
    logic [BUS_WIDTH-1:0] ab_hold;
    logic [BUS_WIDTH-1:0] ba_hold;
    logic [BUS_WIDTH-1:0] pipe [PIPE_STAGES];

    // Software visible state
    logic                 snoop_en;
    logic                 snoop_src;
    logic                 overflow;
    logic [CNT_WIDTH-1:0] ab_count;
    logic [CNT_WIDTH-1:0] ba_count;
    logic [31:0]          rdata_q;

    // Next values
    logic [CNT_WIDTH-1:0] next_ab_count;
    logic [CNT_WIDTH-1:0] next_ba_count;
    logic                 next_overflow;

    // Snoop buffer wiring
    logic [BUS_WIDTH-1:0]   fifo_in_data;
    logic                   fifo_in_valid;
    logic                   fifo_in_ready;
    logic                   fifo_out_valid;
    logic                   fifo_pop;
    logic [BUS_WIDTH-1:0]   fifo_out_data;
    logic [LEVEL_WIDTH-1:0] fifo_level;

    // Rising edges of the sampled device clocks
    // Device clocks are plain inputs here: high and low phases must each
    // last one system clock, or the edge is lost
    // Trade-off: one clock domain inside, a lower ceiling on pin clock rate
    wire ab_rise = a_to_b_clock && !ab_clk_q;
    wire s1_rise = b_to_a_stage_one_clock && !s1_clk_q;
    wire s2_rise = b_to_a_stage_two_clock && !s2_clk_q;

    // Load strobes, each gated by its own direction's enable
    wire ab_load = ab_rise && !a_to_b_clock_enable_n;
    wire s1_load = s1_rise && !b_to_a_clock_enable_n;
    wire s2_load = s2_rise && !b_to_a_clock_enable_n;

    // Stage-two source: B directly, or the last stage-one stage
    wire [BUS_WIDTH-1:0] ba_src = path_select ? b_in : pipe[PIPE_STAGES-1];

    // Register port decode
    // ADDR_CTRL snoop enable and source, read-write
    // ADDR_STATUS buffer level, flags and pin state; overflow write-one-clear
    // ADDR_SNOOP read pops one buffered word, top bit marks it valid
    // ADDR_AB_HOLD and ADDR_BA_HOLD holding registers, read only
    // ADDR_AB_COUNT and ADDR_BA_COUNT load counts, any write clears
    // Only the snoop read has a side effect; other reads are free
    wire sel_ctrl     = (reg_addr == ADDR_CTRL);
    wire sel_status   = (reg_addr == ADDR_STATUS);
    wire sel_snoop    = (reg_addr == ADDR_SNOOP);
    wire sel_ab_hold  = (reg_addr == ADDR_AB_HOLD);
    wire sel_ba_hold  = (reg_addr == ADDR_BA_HOLD);
    wire sel_ab_count = (reg_addr == ADDR_AB_COUNT);
    wire sel_ba_count = (reg_addr == ADDR_BA_COUNT);

    wire wr_ctrl      = reg_wr && sel_ctrl;
    wire wr_status    = reg_wr && sel_status;
    wire wr_ab_count  = reg_wr && sel_ab_count;
    wire wr_ba_count  = reg_wr && sel_ba_count;
    wire ovf_clear    = wr_status && reg_wdata[STAT_OVF_BIT];

    // Pins: output enables follow the controls directly, low means driving
    // The pad ring floats a port while its enable is high; the holding
    // registers behind it keep loading, so data is ready once it drives
    // Enables are not registered, so a port turns on in the same cycle
    assign a_out  = ba_hold;
    assign b_out  = ab_hold;
    assign a_oe_n = b_to_a_output_enable_n;
    assign b_oe_n = a_to_b_output_enable_n;

    // Edge history; device clocks are sampled as ordinary inputs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ab_clk_q <= 1'b0;
            s1_clk_q <= 1'b0;
            s2_clk_q <= 1'b0;
        end else begin
            ab_clk_q <= a_to_b_clock;
            s1_clk_q <= b_to_a_stage_one_clock;
            s2_clk_q <= b_to_a_stage_two_clock;
        end
    end

    // A-to-B holding register, the single stage in this direction
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ab_hold <= HOLD_RST;
        end else if (ab_load) begin
            ab_hold <= a_in;
        end
    end

    // Stage-one pipeline; loads whatever the select, which keeps it primed
    // for a switch to pipeline mode without waiting for fresh edges
    // In direct mode the chain still shifts, but nothing reads its end
    generate
        for (genvar i = 0; i < PIPE_STAGES; i++) begin : g_stage
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    pipe[i] <= HOLD_RST;
                end else if (s1_load) begin
                    pipe[i] <= (i == 0) ? b_in : pipe[(i == 0) ? 0 : i-1];
                end
            end
        end
    endgenerate

    // Stage-two register drives A in both modes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ba_hold <= HOLD_RST;
        end else if (s2_load) begin
            ba_hold <= ba_src;
        end
    end

    // Snoop source: loads of either direction, picked by software
    assign fifo_in_data  = snoop_src ? ba_src : a_in;
    assign fifo_in_valid = snoop_en && (snoop_src ? s2_load : ab_load);
    assign fifo_pop      = reg_rd && sel_snoop;
    assign snoop_ready   = fifo_in_ready;

    // Buffer between the data path and software; a full buffer drops the
    // word rather than stall the pins, since the pins must never wait
    // Overflow is sticky so a drop is never missed between status reads
    rbt_fifo #(
        .WIDTH (BUS_WIDTH),
        .DEPTH (SNOOP_DEPTH)
    ) u_snoop (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    // Counters and sticky flag; a new event beats a clear in the same cycle
    // so no load is ever lost to a software clear
    always_comb begin
        next_ab_count = wr_ab_count ? COUNT_RST : ab_count;
        next_ba_count = wr_ba_count ? COUNT_RST : ba_count;
        next_overflow = ovf_clear ? 1'b0 : overflow;
        if (ab_load) begin
            next_ab_count = next_ab_count + 1'b1;
        end
        if (s2_load) begin
            next_ba_count = next_ba_count + 1'b1;
        end
        if (fifo_in_valid && !fifo_in_ready) begin
            next_overflow = 1'b1;
        end
    end

    // Control fields, written only from the register port
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            snoop_en  <= CTRL_SNOOP_EN_RST;
            snoop_src <= CTRL_SNOOP_SRC_RST;
        end else if (wr_ctrl) begin
            snoop_en  <= reg_wdata[CTRL_SNOOP_EN_BIT];
            snoop_src <= reg_wdata[CTRL_SNOOP_SRC_BIT];
        end
    end

    // Sticky overflow flag
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            overflow <= 1'b0;
        end else begin
            overflow <= next_overflow;
        end
    end

    // Load counters; they wrap silently, software reads them as deltas
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ab_count <= COUNT_RST;
            ba_count <= COUNT_RST;
        end else begin
            ab_count <= next_ab_count;
            ba_count <= next_ba_count;
        end
    end

    // Read words, assembled before the registered return
    wire [31:0] ctrl_word;
    wire [31:0] status_word;
    wire [31:0] snoop_word;
    wire [31:0] read_word;

    assign ctrl_word = {30'h00000000, snoop_src, snoop_en};

    // A driven sits at bit 13 above B driven at bit 12, the reverse of the STAT_ positions
    assign status_word = {18'h00000,
                          !b_to_a_output_enable_n,  // A driven
                          !a_to_b_output_enable_n,  // B driven
                          path_select,
                          overflow,
                          !fifo_in_ready,
                          !fifo_out_valid,
                          3'h0,
                          fifo_level};

    // Bit 31 tells software whether the popped word was real
    assign snoop_word = {fifo_out_valid, 13'h0000,
                         fifo_out_valid ? fifo_out_data : HOLD_RST};

    // Data registers widened to the bus word, high bits zero
    wire [31:0] ab_hold_word;
    wire [31:0] ba_hold_word;
    wire [31:0] ab_count_word;
    wire [31:0] ba_count_word;

    assign ab_hold_word  = {14'h0000, ab_hold};
    assign ba_hold_word  = {14'h0000, ba_hold};
    assign ab_count_word = {16'h0000, ab_count};
    assign ba_count_word = {16'h0000, ba_count};

    // Unmapped offsets read as zero; a priority chain is safe here since
    // the selects come from one address and never overlap
    assign read_word = sel_ctrl     ? ctrl_word :
                       sel_status   ? status_word :
                       sel_snoop    ? snoop_word :
                       sel_ab_hold  ? ab_hold_word :
                       sel_ba_hold  ? ba_hold_word :
                       sel_ab_count ? ab_count_word :
                       sel_ba_count ? ba_count_word :
                       32'h00000000;

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            rdata_q <= read_word;
        end else begin
            rdata_q <= 32'h00000000;
        end
    end

    assign reg_rdata = rdata_q;

endmodule

/* File: tb/rbt_core_assertions.sv */
`timescale 1ns/1ps
module rbt_core_assertions
    import rbt_pkg::*;
(
    // Clock and reset
    input wire logic                          sys_clk,
    input wire logic                          rst,
    // Port pins
    input wire logic [rbt_pkg::BUS_WIDTH-1:0] a_in,
    input wire logic [rbt_pkg::BUS_WIDTH-1:0] a_out,
    input wire logic                          a_oe_n,
    input wire logic [rbt_pkg::BUS_WIDTH-1:0] b_in,
    input wire logic [rbt_pkg::BUS_WIDTH-1:0] b_out,
    input wire logic                          b_oe_n,
    // Direction controls
    input wire logic                          a_to_b_clock,
    input wire logic                          a_to_b_clock_enable_n,
    input wire logic                          a_to_b_output_enable_n,
    input wire logic                          b_to_a_stage_one_clock,
    input wire logic                          b_to_a_stage_two_clock,
    input wire logic                          b_to_a_clock_enable_n,
    input wire logic                          b_to_a_output_enable_n,
    input wire logic                          path_select,
    // Register port
    input wire logic                          reg_rd,
    input wire logic [31:0]                   reg_rdata
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic                 p_ab;
    logic                 p_s1;
    logic                 p_s2;
    logic [BUS_WIDTH-1:0] sh0;
    logic [BUS_WIDTH-1:0] sh1;
    logic [BUS_WIDTH-1:0] sh2;

    // Qualified rises; history starts at 0 so a clock high at release counts
    wire ab_go = a_to_b_clock & ~p_ab & ~a_to_b_clock_enable_n;
    wire s1_go = b_to_a_stage_one_clock & ~p_s1 & ~b_to_a_clock_enable_n;
    wire s2_go = b_to_a_stage_two_clock & ~p_s2 & ~b_to_a_clock_enable_n;

    // Shadow of the stage-one chain, so the last stage can be judged
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            {p_ab, p_s1, p_s2} <= 3'h0;
            {sh0, sh1, sh2} <= '0;
        end else begin
            {p_ab, p_s1, p_s2} <= {a_to_b_clock, b_to_a_stage_one_clock, b_to_a_stage_two_clock};
            if (s1_go) begin
                {sh0, sh1, sh2} <= {b_in, sh0, sh1};
            end
        end
    end

    sequence s_direct_load;
        s2_go && path_select;
    endsequence
    sequence s_piped_load;
        s2_go && !path_select;
    endsequence

    chk_ab_load: assert property (ab_go |=> b_out == $past(a_in))
        else $error("b_out missed the A load");
    chk_ab_hold: assert property (!ab_go |=> $stable(b_out))
        else $error("b_out moved without a load");
    chk_ba_direct: assert property (s_direct_load |=> a_out == $past(b_in))
        else $error("a_out missed the direct load");
    chk_ba_piped: assert property (s_piped_load |=> a_out == $past(sh2))
        else $error("a_out missed the pipeline word");
    chk_a_hold: assert property (!s2_go |=> $stable(a_out))
        else $error("a_out moved without a load");
    chk_a_enable: assert property (a_oe_n == b_to_a_output_enable_n)
        else $error("a_oe_n differs from its enable");
    chk_b_enable: assert property (b_oe_n == a_to_b_output_enable_n)
        else $error("b_oe_n differs from its enable");
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("reg_rdata not zero outside a read");
endmodule

bind rbt_core rbt_core_assertions u_chk (.sys_clk, .rst, .a_in, .a_out, .a_oe_n, .b_in, .b_out,
    .b_oe_n, .a_to_b_clock, .a_to_b_clock_enable_n, .a_to_b_output_enable_n,
    .b_to_a_stage_one_clock, .b_to_a_stage_two_clock, .b_to_a_clock_enable_n,
    .b_to_a_output_enable_n, .path_select, .reg_rd, .reg_rdata);

/* File: tb/rbt_bus_partner.sv */
`timescale 1ns/1ps
module rbt_bus_partner
    import rbt_pkg::*;
(
    // Block side of both ports
    input  wire logic [rbt_pkg::BUS_WIDTH-1:0] a_out,
    input  wire logic                          a_oe_n,
    input  wire logic [rbt_pkg::BUS_WIDTH-1:0] b_out,
    input  wire logic                          b_oe_n,
    // Levels the far-side logic offers
    input  wire logic [rbt_pkg::BUS_WIDTH-1:0] a_drv,
    input  wire logic [rbt_pkg::BUS_WIDTH-1:0] b_drv,
    // Resolved wire levels
    output wire logic [rbt_pkg::BUS_WIDTH-1:0] a_in,
    output wire logic [rbt_pkg::BUS_WIDTH-1:0] b_in
);
    // Far side backs off while the block drives, to avoid contention
    assign a_in = a_oe_n ? a_drv : a_out;
    assign b_in = b_oe_n ? b_drv : b_out;
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import rbt_pkg::*;
    logic                 sys_clk = 1'b0;
    logic                 rst = 1'b1;
    logic [BUS_WIDTH-1:0] a_drv = 18'h00000;
    logic [BUS_WIDTH-1:0] b_drv = 18'h00000;
    wire  [BUS_WIDTH-1:0] a_in, a_out, b_in, b_out;
    wire                  a_oe_n, b_oe_n, snoop_ready;
    wire  [31:0]          reg_rdata;
    logic                 ab_clk = 1'b0, s1_clk = 1'b0, s2_clk = 1'b0, sel = 1'b0;
    logic                 ab_en_n = 1'b1, ba_en_n = 1'b1, ab_oe_n = 1'b1, ba_oe_n = 1'b1;
    logic [7:0]           reg_addr = 8'h00;
    logic [31:0]          reg_wdata = 32'h0;
    logic                 reg_wr = 1'b0, reg_rd = 1'b0;
    int                   fails = 0, comparisons = 0;

    always #12.5 sys_clk = ~sys_clk;

    rbt_core uut (.sys_clk, .rst, .a_in, .a_out, .a_oe_n, .b_in, .b_out, .b_oe_n,
        .a_to_b_clock(ab_clk), .a_to_b_clock_enable_n(ab_en_n), .a_to_b_output_enable_n(ab_oe_n),
        .b_to_a_stage_one_clock(s1_clk), .b_to_a_stage_two_clock(s2_clk),
        .b_to_a_clock_enable_n(ba_en_n), .b_to_a_output_enable_n(ba_oe_n), .path_select(sel),
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .snoop_ready);
    rbt_bus_partner far_end (.a_out, .a_oe_n, .b_out, .b_oe_n, .a_drv, .b_drv, .a_in, .b_in);

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // High for one cycle, then low for one, so every pulse is a fresh rise
    task automatic pulse(input logic [2:0] m);
        {s2_clk, s1_clk, ab_clk} <= m;
        @(posedge sys_clk);
        {s2_clk, s1_clk, ab_clk} <= 3'h0;
        @(posedge sys_clk);
    endtask

    // Extra edge after a write so a following strobe is never set twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        chk("reg_rdata", reg_rdata & mask, exp);
    endtask

    task automatic t_ab();
        ab_en_n <= 1'b0;
        a_drv <= 18'h2aaaa;
        pulse(3'h1);
        chk("b_out", 32'(b_out), 32'h2aaaa);
        chk("b_oe_n", 32'(b_oe_n), 32'h1);
        ab_oe_n <= 1'b0;
        a_drv <= 18'h15555;
        pulse(3'h1);
        chk("b_in", 32'(b_in), 32'h15555);
        a_drv <= 18'h3ffff;
        ba_en_n <= 1'b0;
        pulse(3'h6);
        chk("b_out", 32'(b_out), 32'h15555);
        ab_en_n <= 1'b1;
        pulse(3'h1);
        chk("b_out", 32'(b_out), 32'h15555);
    endtask

    task automatic t_ba_direct();
        ab_oe_n <= 1'b1;
        ba_oe_n <= 1'b0;
        sel <= 1'b1;
        b_drv <= 18'h20001;
        pulse(3'h4);
        chk("a_in", 32'(a_in), 32'h20001);
        chk("a_oe_n", 32'(a_oe_n), 32'h0);
        b_drv <= 18'h1fffe;
        pulse(3'h2);
        chk("a_out", 32'(a_out), 32'h20001);
        ba_en_n <= 1'b1;
        sel <= 1'b0;
        pulse(3'h6);
        sel <= 1'b1;
        pulse(3'h6);
        chk("a_out", 32'(a_out), 32'h20001);
    endtask

    // Stage two fired with the fourth shift must take the older word
    task automatic t_ba_pipe();
        ba_en_n <= 1'b0;
        sel <= 1'b0;
        for (int i = 1; i <= 3; i++) begin
            b_drv <= 18'(i * 17);
            pulse(3'h2);
        end
        b_drv <= 18'h00044;
        pulse(3'h6);
        chk("a_out", 32'(a_out), 32'h11);
        pulse(3'h4);
        chk("a_out", 32'(a_out), 32'h22);
    endtask

    task automatic t_regs();
        rd(ADDR_CTRL, 32'h0, 32'hffffffff);
        wr(ADDR_CTRL, 32'h3);
        wr(8'h1c, 32'hffffffff);
        rd(ADDR_CTRL, 32'h3, 32'hffffffff);
        rd(8'h1c, 32'h0, 32'hffffffff);
        rd(ADDR_STATUS, 32'h2100, 32'hffffffff);
        rd(ADDR_AB_HOLD, 32'h15555, 32'hffffffff);
        rd(ADDR_BA_HOLD, 32'h22, 32'hffffffff);
        rd(ADDR_BA_COUNT, 32'h4, 32'hffffffff);
        wr(ADDR_CTRL, 32'h0);
    endtask

    // Snoop buffer filled past full, overflow cleared, then drained in order
    task automatic t_fifo();
        ba_oe_n <= 1'b1;
        wr(ADDR_AB_COUNT, 32'h0);
        wr(ADDR_CTRL, 32'h1);
        ab_en_n <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            a_drv <= 18'(i + 256);
            pulse(3'h1);
        end
        chk("snoop_ready", 32'(snoop_ready), 32'h0);
        a_drv <= 18'h3ffff;
        pulse(3'h1);
        rd(ADDR_STATUS, 32'h610, 32'h71f);
        wr(ADDR_STATUS, 32'h400);
        rd(ADDR_STATUS, 32'h0, 32'h400);
        rd(ADDR_AB_COUNT, 32'h11, 32'hffffffff);
        for (int i = 0; i < 16; i++) begin
            rd(ADDR_SNOOP, 32'h80000100 + 32'(i), 32'hffffffff);
        end
        rd(ADDR_SNOOP, 32'h0, 32'hffffffff);
        chk("snoop_ready", 32'(snoop_ready), 32'h1);
        wr(ADDR_CTRL, 32'h3);
        sel <= 1'b1;
        b_drv <= 18'h0abcd;
        pulse(3'h4);
        chk("a_out", 32'(a_out), 32'h0abcd);
        rd(ADDR_SNOOP, 32'h8000abcd, 32'hffffffff);
        rd(ADDR_BA_COUNT, 32'h5, 32'hffffffff);
        wr(ADDR_CTRL, 32'h0);
    endtask

    task automatic print_verdict();
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk("b_out", 32'(b_out), 32'h0);
        t_ab();
        t_ba_direct();
        t_ba_pipe();
        t_regs();
        t_fifo();
        print_verdict();
    end

    // Run needs about 140 cycles; twenty times that means a hang
    initial begin
        #75000;
        fails++;
        print_verdict();
    end
endmodule
